// ---- shared/oae_pkg.sv ----
package oae_pkg;
   // ----------------------------------------------------------------
   // operand word layout
   // ----------------------------------------------------------------
   localparam int unsigned FIELD_W = 14;
   localparam int unsigned SCALE_W = 15;
   localparam int unsigned FRAC_W = 15;
   localparam int unsigned MODE_LSB = 14;
   localparam int unsigned WORD_ALIGN_BITS = 4;

   // addressing mode codes, shared by both axes
   typedef enum logic [1:0] {
      MODE_ABSOLUTE = 2'h0,
      MODE_VIEWPORT = 2'h1,
      MODE_RELATIVE = 2'h2,
      MODE_INDIRECT = 2'h3
   } oae_mode_e;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WORD1 = 8'h04;
   localparam logic [7:0] OFS_WORD2 = 8'h08;
   localparam logic [7:0] OFS_VIEWPORT = 8'h0C;
   localparam logic [7:0] OFS_PEN = 8'h10;
   localparam logic [7:0] OFS_SCALE = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_RESULT = 8'h1C;
   localparam logic [7:0] OFS_FRAC_ERR = 8'h20;

   // field positions inside the X,Y pair registers and the control and status registers
   localparam int unsigned PAIR_X_LSB = 0;
   localparam int unsigned PAIR_Y_LSB = 16;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [13:0] RST_COORD = 14'h0000;
   localparam logic [14:0] RST_SCALE = 15'h0000;
   localparam logic [14:0] RST_FRAC = 15'h0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage

// ---- verilog/oae_operand_eval.sv ----
// ------------------------------------------------------------------
// operand address evaluator
// ------------------------------------------------------------------
// Behaviour
// - two-bit mode field picks absolute, viewport, relative or indirect for both axes
// - X field is 14-bit signed, multiplied by nonzero X scale when mode allows
// - each pair is two independent axis translations, each with its own scale
// - no scaling in absolute or indirect; viewport/relative scale only when factor nonzero
// - multiplier gives 29-bit product: 14-bit integer, 15-bit fraction
// - absolute uses field directly, ignores scale, keeps fractional error
// - absolute origin upper-left, Y grows downward
// - unscaled viewport adds viewport location, keeps fractional error
// - scaled viewport adds location to product integer, ignores old fraction, stores new
// - viewport Y positive lands above location; truncation moves pixel up
// - unscaled relative adds pen position, keeps fractional error
// - relative Y positive lands above pen position
// - scaled relative adds stored fraction into product, saves resulting fraction
// - indirect fetches new pair from X,Y and X,Y+1 of plane zero
// - fetched pair is evaluated normally, including further indirection
module oae_operand_eval (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // display memory read port, plane 0
   output logic o_mem_req,
   output logic [13:0] o_mem_x,
   output logic [13:0] o_mem_y,
   input wire logic i_mem_valid,
   input wire logic [15:0] i_mem_data,
   // evaluation result
   output logic [13:0] o_eff_x,
   output logic [13:0] o_eff_y,
   output logic o_busy,
   output logic o_done
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EVAL,
      ST_FETCH_W1,
      ST_FETCH_W2
   } oae_state_e;

   typedef struct packed {
      oae_state_e state;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic [15:0] word1;
      logic [15:0] word2;
      logic [13:0] vp_x;
      logic [13:0] vp_y;
      logic [13:0] pen_x;
      logic [13:0] pen_y;
      logic [14:0] scale_x;
      logic [14:0] scale_y;
      logic [14:0] ferr_x;
      logic [14:0] ferr_y;
      logic [13:0] eff_x;
      logic [13:0] eff_y;
      logic done;
      logic mem_req;
      logic [13:0] mem_x;
      logic [13:0] mem_y;
   } oae_regs_s;

   oae_regs_s r_q;
   oae_regs_s r_d;

   // ----------------------------------------------------------------
   // one axis translation: returns {update_frac, frac, address}
   // ----------------------------------------------------------------
   // flip is set for Y in viewport and relative mode: the field is negated before
   // the multiply so that floor truncation moves the pixel up the screen
   // negating -8192 gives +8192, which still fits the fifteen-bit signed copy
   // the factor is unsigned, so a zero-extended copy keeps the sign of the field
   // the stored fraction is unsigned and joins the sum only in relative mode;
   // viewport scaling starts afresh each time and only replaces the stored fraction
   // the unscaled path hands the old fraction back so the caller can leave it alone
   function automatic logic [29:0] eval_axis(input logic [13:0] fld, input logic [13:0] base,
         input logic [14:0] scl, input logic [1:0] mode, input logic [14:0] ferr, input logic flip);
      logic signed [14:0] f;
      logic signed [30:0] p;
      logic scaled;
      logic [13:0] addr;
      logic [14:0] frac;
      f = $signed({fld[13], fld});
      if (flip) begin
         f = -f;
      end
      scaled = ((mode == oae_pkg::MODE_VIEWPORT) || (mode == oae_pkg::MODE_RELATIVE))
               && (scl != oae_pkg::RST_SCALE);
      p = f * $signed({1'b0, scl});
      if (mode == oae_pkg::MODE_RELATIVE) begin
         p = p + $signed({16'h0000, ferr});
      end
      // integer part is the fourteen bits above the fraction; anything higher falls
      // away, as the address wraps in fourteen bits like the unscaled sum does
      if (scaled) begin
         addr = base + p[28:15];
         frac = p[14:0];
      end else begin
         addr = base + f[13:0];
         frac = ferr;
      end
      return {scaled, frac, addr};
   endfunction

   // ----------------------------------------------------------------
   // axis evaluation of the current pair
   // ----------------------------------------------------------------
   logic [1:0] mode;
   logic [13:0] base_x;
   logic [13:0] base_y;
   logic [29:0] res_x;
   logic [29:0] res_y;

   // mode picks the offset for both axes at once; absolute and indirect add zero
   // the mode sits in the two top bits of the first word and covers both axes
   // indirect fields never reach the result through this path: the sequencer
   // sends them to the fetch port instead
   always_comb begin
      mode = r_q.word1[15:oae_pkg::MODE_LSB];
      unique case (mode)
         oae_pkg::MODE_VIEWPORT: begin
            base_x = r_q.vp_x;
            base_y = r_q.vp_y;
         end
         oae_pkg::MODE_RELATIVE: begin
            base_x = r_q.pen_x;
            base_y = r_q.pen_y;
         end
         default: begin
            base_x = oae_pkg::RST_COORD;
            base_y = oae_pkg::RST_COORD;
         end
      endcase
   end

   // the X axis is never flipped: positive X always moves right
   // Y is flipped in every mode but absolute, where Y grows down the screen
   // two independent translations, each with its own scale and error
   assign res_x = eval_axis(r_q.word1[13:0], base_x, r_q.scale_x, mode, r_q.ferr_x, 1'b0);
   assign res_y = eval_axis(r_q.word2[13:0], base_y, r_q.scale_y, mode, r_q.ferr_y,
                            mode != oae_pkg::MODE_ABSOLUTE);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic addr_phase;
   logic start_wr;
   logic wr_data_ok;

   // word transfers only; narrower sizes still hit the whole register
   // htrans bit one marks NONSEQ and SEQ; IDLE and BUSY start nothing
   // the slave has no wait states, so write data always arrives in the cycle after
   // its address phase; wr_pend carries the address phase forward by one cycle
   // a start is recognised in the data phase, together with its write data
   assign addr_phase = i_hsel && i_hready && i_htrans[1];
   assign wr_data_ok = r_q.wr_pend;
   assign start_wr = wr_data_ok && (r_q.wr_addr == oae_pkg::OFS_CTRL)
                     && i_hwdata[oae_pkg::CTRL_START_BIT];

   // read mux used in the address phase; write-only and unused offsets read zero
   // so that software probing the map never sees a stale bus value
   function automatic logic [31:0] read_mux(input oae_regs_s s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         oae_pkg::OFS_WORD1: v = {16'h0000, s.word1};
         oae_pkg::OFS_WORD2: v = {16'h0000, s.word2};
         oae_pkg::OFS_VIEWPORT: v = {2'h0, s.vp_y, 2'h0, s.vp_x};
         oae_pkg::OFS_PEN: v = {2'h0, s.pen_y, 2'h0, s.pen_x};
         oae_pkg::OFS_SCALE: v = {1'h0, s.scale_y, 1'h0, s.scale_x};
         oae_pkg::OFS_STATUS: v = {30'h0000_0000, s.done, s.state != ST_IDLE};
         oae_pkg::OFS_RESULT: v = {2'h0, s.eff_y, 2'h0, s.eff_x};
         oae_pkg::OFS_FRAC_ERR: v = {1'h0, s.ferr_y, 1'h0, s.ferr_x};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      // defaults hold every field; only the branches below move anything
      r_d = r_q;
      // address phase: reads are sampled now so hrdata comes from a flop
      r_d.wr_pend = addr_phase && i_hwrite;
      if (addr_phase) begin
         r_d.wr_addr = i_haddr[7:0];
         r_d.rdata = i_hwrite ? oae_pkg::RST_RDATA : read_mux(r_q, i_haddr[7:0]);
      end
      // data phase writes; operand words are locked while an evaluation runs
      // viewport, pen and scale are not locked: a write during a fetch is seen by
      // the evaluation that follows the fetch
      if (wr_data_ok) begin
         unique case (r_q.wr_addr)
            oae_pkg::OFS_WORD1: begin
               if (r_q.state == ST_IDLE) begin
                  r_d.word1 = i_hwdata[15:0];
               end
            end
            oae_pkg::OFS_WORD2: begin
               if (r_q.state == ST_IDLE) begin
                  r_d.word2 = i_hwdata[15:0];
               end
            end
            oae_pkg::OFS_VIEWPORT: begin
               r_d.vp_x = i_hwdata[oae_pkg::PAIR_X_LSB +: 14];
               r_d.vp_y = i_hwdata[oae_pkg::PAIR_Y_LSB +: 14];
            end
            oae_pkg::OFS_PEN: begin
               r_d.pen_x = i_hwdata[oae_pkg::PAIR_X_LSB +: 14];
               r_d.pen_y = i_hwdata[oae_pkg::PAIR_Y_LSB +: 14];
            end
            oae_pkg::OFS_SCALE: begin
               r_d.scale_x = i_hwdata[oae_pkg::PAIR_X_LSB +: 15];
               r_d.scale_y = i_hwdata[oae_pkg::PAIR_Y_LSB +: 15];
            end
            default: begin
            end
         endcase
      end
      // evaluation sequencer
      // EVAL finishes a direct pair in one cycle or hands an indirect pair to the
      // fetch port; FETCH_W1 and FETCH_W2 each wait for one word from plane zero
      // the fetched pair returns to EVAL, so nesting has no depth limit
      // limitation: a chain of indirect pairs that points at itself never finishes
      unique case (r_q.state)
         ST_IDLE: begin
            // done is cleared here and set only in EVAL, so the two never meet
            if (start_wr) begin
               r_d.done = 1'b0;
               r_d.state = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (mode == oae_pkg::MODE_INDIRECT) begin
               // fields are a raw integer address; X must be word aligned
               r_d.mem_x = r_q.word1[13:0];
               r_d.mem_y = r_q.word2[13:0];
               r_d.mem_req = 1'b1;
               r_d.state = ST_FETCH_W1;
            end else begin
               // fractions move only on a scaled evaluation of that axis
               r_d.eff_x = res_x[13:0];
               r_d.eff_y = res_y[13:0];
               if (res_x[29]) begin
                  r_d.ferr_x = res_x[28:14];
               end
               if (res_y[29]) begin
                  r_d.ferr_y = res_y[28:14];
               end
               r_d.done = 1'b1;
               r_d.state = ST_IDLE;
            end
         end
         ST_FETCH_W1: begin
            if (i_mem_valid) begin
               // first word carries the mode and X; the row below holds Y
               r_d.word1 = i_mem_data;
               r_d.mem_y = r_q.mem_y + 14'h0001;
               r_d.state = ST_FETCH_W2;
            end
         end
         ST_FETCH_W2: begin
            if (i_mem_valid) begin
               // the request drops with the last word, so no stray third read is made
               r_d.word2 = i_mem_data;
               r_d.mem_req = 1'b0;
               r_d.state = ST_EVAL;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // every field, fractional errors included, starts at zero; the reset is
   // asynchronous so a fetch request drops at once when the device is reset
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         r_q.state <= ST_IDLE;
         r_q.wr_pend <= 1'b0;
         r_q.wr_addr <= oae_pkg::OFS_CTRL;
         r_q.rdata <= oae_pkg::RST_RDATA;
         r_q.word1 <= oae_pkg::RST_WORD;
         r_q.word2 <= oae_pkg::RST_WORD;
         r_q.vp_x <= oae_pkg::RST_COORD;
         r_q.vp_y <= oae_pkg::RST_COORD;
         r_q.pen_x <= oae_pkg::RST_COORD;
         r_q.pen_y <= oae_pkg::RST_COORD;
         r_q.scale_x <= oae_pkg::RST_SCALE;
         r_q.scale_y <= oae_pkg::RST_SCALE;
         r_q.ferr_x <= oae_pkg::RST_FRAC;
         r_q.ferr_y <= oae_pkg::RST_FRAC;
         r_q.eff_x <= oae_pkg::RST_COORD;
         r_q.eff_y <= oae_pkg::RST_COORD;
         r_q.done <= 1'b0;
         r_q.mem_req <= 1'b0;
         r_q.mem_x <= oae_pkg::RST_COORD;
         r_q.mem_y <= oae_pkg::RST_COORD;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // zero wait states; the slave never errors
   // hresp is tied to OKAY: refused writes are dropped silently
   // busy is decoded from the state flop, so it rises in the cycle after the start
   // write lands and falls in the cycle in which the result registers load
   assign o_hrdata = r_q.rdata;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_mem_req = r_q.mem_req;
   assign o_mem_x = r_q.mem_x;
   assign o_mem_y = r_q.mem_y;
   assign o_eff_x = r_q.eff_x;
   assign o_eff_y = r_q.eff_y;
   assign o_busy = r_q.state != ST_IDLE;
   assign o_done = r_q.done;

endmodule

// ---- bench/oae_operand_eval_asserts.sv ----
module oae_operand_eval_asserts (
   // clock, reset and bus
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // fetch port and results
   input wire logic o_mem_req,
   input wire logic [13:0] o_mem_x,
   input wire logic [13:0] o_mem_y,
   input wire logic i_mem_valid,
   input wire logic [13:0] o_eff_x,
   input wire logic [13:0] o_eff_y,
   input wire logic o_busy,
   input wire logic o_done
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // ----------------------------
   // helper state
   // ----------------------------
   logic ctl_q;
   logic beat_q;
   // ctl_q marks a control write in its data phase; beat_q tells first fetch word from second
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ctl_q <= 1'b0;
         beat_q <= 1'b0;
      end else begin
         ctl_q <= i_hsel && i_hready && i_htrans[1] && i_hwrite && i_haddr[7:0] == oae_pkg::OFS_CTRL;
         beat_q <= beat_q ^ (o_mem_req && i_mem_valid);
      end
   end
   // bus and evaluation sequencing
   AST_BUS_OK: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not ready or not okay");
   AST_START: assert property (ctl_q && i_hwdata[0] && !o_busy |=> o_busy && !o_done)
      else $error("start not taken");
   AST_EVAL_ONE: assert property ($rose(o_busy) |=> o_done || o_mem_req)
      else $error("evaluation did not finish or fetch");
   AST_REFETCH: assert property ($fell(o_mem_req) |-> o_busy ##1 (o_done || o_mem_req))
      else $error("fetched pair not evaluated");
   AST_DONE_HOLD: assert property (o_done |=> o_done || o_busy)
      else $error("done dropped without start");
   AST_EFF_HOLD: assert property (!o_busy |=> $stable(o_eff_x) && $stable(o_eff_y))
      else $error("result moved while idle");
   // fetch port: second word is one row lower, request and Y address hold while waiting
   AST_FETCH_STEP: assert property (o_mem_req && i_mem_valid && !beat_q
         |=> o_mem_req && o_mem_y == $past(o_mem_y) + 14'h1 && $stable(o_mem_x))
      else $error("second word address wrong");
   AST_FETCH_END: assert property (o_mem_req && i_mem_valid && beat_q |=> !o_mem_req)
      else $error("fetch did not end after two words");
   AST_MEM_HOLD: assert property (o_mem_req && !i_mem_valid |=> o_mem_req && $stable(o_mem_y))
      else $error("fetch request changed while waiting");
   AST_REQ_BUSY: assert property (o_mem_req |-> o_busy)
      else $error("fetch while idle");
   cover property ($rose(o_done));
   cover property ($fell(o_mem_req));
   cover property (o_mem_req && !i_mem_valid ##1 o_mem_req);
endmodule

bind oae_operand_eval oae_operand_eval_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_mem_req(o_mem_req), .o_mem_x(o_mem_x), .o_mem_y(o_mem_y),
   .i_mem_valid(i_mem_valid), .o_eff_x(o_eff_x), .o_eff_y(o_eff_y), .o_busy(o_busy), .o_done(o_done));

// ---- bench/oae_dispmem_model.sv ----
module oae_dispmem_model (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // plane 0 read port
   input wire logic i_mem_req,
   input wire logic [13:0] i_mem_x,
   input wire logic [13:0] i_mem_y,
   input wire logic [3:0] i_wait,
   output logic o_mem_valid,
   output logic [15:0] o_mem_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:15];
   logic [3:0] cnt;
   // answer after i_wait idle cycles; off-strobe data is inverted so stale reads show
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 4'h0;
         o_mem_valid <= 1'b0;
         o_mem_data <= 16'h0000;
      end else if (i_mem_req && !o_mem_valid && cnt == i_wait) begin
         o_mem_valid <= 1'b1;
         o_mem_data <= (i_mem_x[3:0] == 4'h0) ? mem[i_mem_y[3:0]] : 16'hDEAD;
         cnt <= 4'h0;
      end else begin
         o_mem_valid <= 1'b0;
         o_mem_data <= ~o_mem_data;
         cnt <= (i_mem_req && !o_mem_valid) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// ---- bench/oae_operand_eval_bench.sv ----
module oae_operand_eval_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------
   // stimulus and wiring
   // ----------------------------
   localparam logic [13:0] VP_X = 14'h0100;
   localparam logic [13:0] VP_Y = 14'h0200;
   localparam logic [13:0] PEN_X = 14'h0123;
   localparam logic [13:0] PEN_Y = 14'h0F00;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] wait_n = 4'h0;
   logic [31:0] hrdata;
   logic hready, hresp, req, vld, busy, done;
   logic [13:0] mx, my, ex, ey;
   logic [15:0] mdata;
   logic [14:0] fe_x = 15'h0;
   logic [14:0] fe_y = 15'h0;
   int fails = 0;
   int tests_run = 0;
   always #50 clk = ~clk;
   oae_operand_eval dut (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .o_mem_req(req), .o_mem_x(mx), .o_mem_y(my),
      .i_mem_valid(vld), .i_mem_data(mdata), .o_eff_x(ex), .o_eff_y(ey), .o_busy(busy), .o_done(done));
   oae_dispmem_model mem_m (.i_clk_sys(clk), .i_rst(rst), .i_mem_req(req), .i_mem_x(mx), .i_mem_y(my),
      .i_wait(wait_n), .o_mem_valid(vld), .o_mem_data(mdata));
   // ----------------------------
   // tasks
   // ----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         fails++;
         $display("unexpected t=%0t got %h want %h", $time, got, want);
      end
   endtask
   // one single transfer; called right after a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] want);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, want);
   endtask
   // returns {effective address, new fraction} for one axis; Y is negated off a base
   function automatic logic [28:0] exp_axis(input logic [13:0] f, input logic [14:0] s, input logic [13:0] b,
         input logic [1:0] m, input logic [14:0] fe, input logic ny);
      logic signed [14:0] sf;
      logic signed [29:0] p;
      sf = ny ? -$signed({f[13], f}) : $signed({f[13], f});
      if (m == 2'h0) return {f, fe};
      if (s == 15'h0) return {b + sf[13:0], fe};
      p = sf * $signed({1'b0, s});
      if (m == 2'h2) p = p + $signed({15'h0, fe});
      return {p[28:15] + b, p[14:0]};
   endfunction
   // w1/w2 are written, e1/e2 the pair finally evaluated (differs only when indirect)
   task automatic eval(input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] e1,
         input logic [15:0] e2, input logic [14:0] sx, input logic [14:0] sy);
      logic [28:0] ax, ay;
      ax = exp_axis(e1[13:0], sx, e1[15:14] == 2'h1 ? VP_X : PEN_X, e1[15:14], fe_x, 1'b0);
      ay = exp_axis(e2[13:0], sy, e1[15:14] == 2'h1 ? VP_Y : PEN_Y, e1[15:14], fe_y, 1'b1);
      wr(oae_pkg::OFS_SCALE, {1'b0, sy, 1'b0, sx});
      wr(oae_pkg::OFS_WORD1, {16'h0, w1});
      wr(oae_pkg::OFS_WORD2, {16'h0, w2});
      wr(oae_pkg::OFS_CTRL, 32'h1);
      @(posedge clk);
      repeat (60) if (done !== 1'b1) @(posedge clk);
      fe_x = ax[14:0];
      fe_y = ay[14:0];
      chk({2'h0, busy, done, ey, ex}, {4'h1, ay[28:15], ax[28:15]});
      rdc(oae_pkg::OFS_RESULT, {2'h0, ay[28:15], 2'h0, ax[28:15]});
      rdc(oae_pkg::OFS_FRAC_ERR, {1'b0, fe_y, 1'b0, fe_x});
      rdc(oae_pkg::OFS_STATUS, 32'h2);
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------
   // test sequence
   // ----------------------------
   initial begin
      mem_m.mem[2] = 16'hC010;
      mem_m.mem[3] = 16'h0004;
      mem_m.mem[4] = 16'h4002;
      mem_m.mem[5] = 16'h0001;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(oae_pkg::OFS_FRAC_ERR, 32'h0);
      wr(8'h24, 32'hFFFF_FFFF);
      rdc(8'h24, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(oae_pkg::OFS_VIEWPORT, {2'h0, VP_Y, 2'h0, VP_X});
         wr(oae_pkg::OFS_PEN, {2'h0, PEN_Y, 2'h0, PEN_X});
         rdc(oae_pkg::OFS_VIEWPORT, {2'h0, VP_Y, 2'h0, VP_X});
         rdc(oae_pkg::OFS_PEN, {2'h0, PEN_Y, 2'h0, PEN_X});
         eval(16'h1FFF, 16'h2000, 16'h1FFF, 16'h2000, 15'h7FFF, 15'h4000);
         eval(16'h7FF0, 16'h0005, 16'h7FF0, 16'h0005, 15'h0, 15'h0);
         eval(16'h4007, 16'h0003, 16'h4007, 16'h0003, 15'h4000, 15'h2000);
         eval(16'h8003, 16'h0001, 16'h8003, 16'h0001, 15'h4000, 15'h0);
         eval(16'hBFFB, 16'h3FFD, 16'hBFFB, 16'h3FFD, 15'h7FFF, 15'h7FFF);
         wait_n <= 4'h3;
         eval(16'hC010, 16'h0002, 16'h4002, 16'h0001, 15'h2000, 15'h0);
         wait_n <= 4'h0;
         eval(16'hC000, 16'h0004, 16'h4002, 16'h0001, 15'h0, 15'h6000);
         // a slow fetch locks the operand words and refuses a second start
         wait_n <= 4'hF;
         wr(oae_pkg::OFS_WORD1, 32'h0000_C000);
         wr(oae_pkg::OFS_WORD2, 32'h0000_0004);
         wr(oae_pkg::OFS_CTRL, 32'h1);
         wr(oae_pkg::OFS_WORD1, 32'h0000_0005);
         wr(oae_pkg::OFS_CTRL, 32'h1);
         rdc(oae_pkg::OFS_WORD1, 32'h0000_C000);
         repeat (80) if (done !== 1'b1) @(posedge clk);
         wait_n <= 4'h0;
         chk({31'h0, done}, 32'h1);
         rdc(oae_pkg::OFS_RESULT, {2'h0, VP_Y - 14'h1, 2'h0, VP_X + 14'h2});
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         fe_x = 15'h0;
         fe_y = 15'h0;
         @(posedge clk);
         rdc(oae_pkg::OFS_FRAC_ERR, 32'h0);
      end
      end_sim();
   end
   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #1000000;
      fails++;
      end_sim();
   end
endmodule
